// File: inc/cpev_pkg.sv
// Overview of operation
// RULE1 - Instructions pass fetch, decode and execute stages in sequence.
// RULE2 - Execute holds arithmetic, product and memory access sections side by side.
// RULE3 - Instructions issue and retire strictly in program order.
// RULE4 - Multi-cycle operations hold decode and execute, stalling younger instructions.
// RULE5 - No operand forwarding; stage structure prevents data hazards.
// RULE6 - Status word: low half flags and three bits, high half mode and state.
// RULE7 - Supervisor call pushes return address and status; supervisor return pops both.
// RULE8 - Debug request enters debug mode unless the debug mask bit is set.
// RULE9 - Debug entry sets the debug active flag and jumps to debug handler.
// RULE10 - Debug entry saves context in dedicated debug return registers, not stack.
// RULE11 - In debug mode the mode bits are freely writable.
// RULE12 - Debug return leaves debug mode and restores the saved context.
// RULE13 - After reset, fetching starts at the fixed reset address.
// RULE14 - Protection miss and supervisor call use fixed offsets from vector base.
// RULE15 - Every other exception has its own fixed offset from vector base.
// RULE16 - Protection violations report fetch-side or data-side by access type.
// RULE17 - An address matching no protection entry raises a miss exception.
// RULE18 - An address matching several entries raises a multiple-hit exception.
// RULE19 - Interrupt handler address is vector base plus controller-supplied offset.
// RULE20 - Autovector offset is 14 bits, reaching 16383 bytes above the base.
// RULE21 - Simultaneous events on one instruction are taken one at a time by priority.
// RULE22 - Events of the oldest instruction are taken before younger instructions' events.
// RULE23 - The priority order among simultaneous events is a parameter table.
package cpev_pkg;
  localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
  localparam int          AV_BITS    = 14;
  // Register byte offsets
  localparam logic [7:0]  A_SR    = 8'h00;
  localparam logic [7:0]  A_EVENT_VECTOR_BASE  = 8'h04;
  localparam logic [7:0]  A_DRA   = 8'h08;
  localparam logic [7:0]  A_DRS   = 8'h0c;
  localparam logic [7:0]  A_CAUSE = 8'h10;
  localparam logic [7:0]  A_PC    = 8'h14;
  // Handler offsets from the vector base
  localparam logic [31:0] OFS_DBG   = 32'h0000_001c;
  localparam logic [31:0] OFS_MULTI = 32'h0000_0014;
  localparam logic [31:0] OFS_IPROT = 32'h0000_0020;
  localparam logic [31:0] OFS_DPROT = 32'h0000_0028;
  localparam logic [31:0] OFS_IMISS = 32'h0000_0050;
  localparam logic [31:0] OFS_DMISS = 32'h0000_0060;
  localparam logic [31:0] OFS_SCALL = 32'h0000_0100;
  // Modes
  localparam logic [2:0]  MODE_APP = 3'h0;
  localparam logic [2:0]  MODE_SUP = 3'h1;
  localparam logic [2:0]  MODE_INT = 3'h2;
  localparam logic [2:0]  MODE_EXC = 3'h6;
  localparam logic [31:0] SR_RESET  = 32'h0080_0000;
  localparam logic [31:0] SR_WMASK  = 32'h07ff_00ff;
  localparam logic [3:0]  PROD_MIN_CYC = 4'h2;
  // Events
  localparam int          NEV   = 8;
  localparam logic [2:0]  EV_DBG   = 3'h0;
  localparam logic [2:0]  EV_MULTI = 3'h1;
  localparam logic [2:0]  EV_IMISS = 3'h2;
  localparam logic [2:0]  EV_IPROT = 3'h3;
  localparam logic [2:0]  EV_DMISS = 3'h4;
  localparam logic [2:0]  EV_DPROT = 3'h5;
  localparam logic [2:0]  EV_SCALL = 3'h6;
  localparam logic [2:0]  EV_IRQ   = 3'h7;
  // Lowest priority first, highest priority in the lowest entry, three bits per entry
  localparam logic [23:0] PRIO_ORDER = {EV_IRQ, EV_SCALL, EV_DPROT, EV_DMISS,
                                        EV_IPROT, EV_IMISS, EV_MULTI, EV_DBG};
  // Instruction kinds and execute sections
  localparam logic [1:0]  K_NORM  = 2'h0;
  localparam logic [1:0]  K_SCALL = 2'h1;
  localparam logic [1:0]  K_RETS  = 2'h2;
  localparam logic [1:0]  K_RETD  = 2'h3;
  localparam logic [1:0]  U_ALU   = 2'h0;
  localparam logic [1:0]  U_PROD  = 2'h1;
  localparam logic [1:0]  U_MEM   = 2'h2;

  typedef struct packed {
    logic [3:0] rsv_hi;
    logic       dbg_active;
    logic       dbg_mask;
    logic [2:0] mode;
    logic [6:0] state;
    logic [7:0] rsv_lo;
    logic       r;
    logic       t;
    logic       l;
    logic       q;
    logic       v;
    logic       n;
    logic       z;
    logic       c;
  } cpev_sr_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [1:0] unit;
    logic [3:0] cycles;
    logic [1:0] hits;
    logic       viol;
  } cpev_fin_t;

  typedef struct packed {
    logic [31:0] ra;
    logic [31:0] sr;
  } cpev_ctx_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic [1:0]  kind;
    logic [1:0]  unit;
    logic [3:0]  cycles;
    logic        imiss;
    logic        iprot;
    logic        imulti;
  } cpev_tok_t;
endpackage

// File: src/cpev_prio_pick.sv
`timescale 1ns/1ps
module cpev_prio_pick #(
  parameter int               N     = 8,
  parameter int               W     = 3,
  parameter logic [N*W-1:0]   ORDER = '0
) (
  input  wire logic [N-1:0]   req,
  output logic                grant_valid,
  output logic [W-1:0]        grant_idx
);
  // Scan lowest priority first so the highest-priority pending entry, the lowest one, wins
  always_comb begin
    grant_valid = 1'b0;
    grant_idx   = '0;
    for (int k = N - 1; k >= 0; k--) begin // RULE23
      if (req[ORDER[k*W +: W]]) begin // RULE21
        grant_valid = 1'b1;
        grant_idx   = ORDER[k*W +: W];
      end
    end
  end
endmodule

// File: src/cpev_top.sv
`timescale 1ns/1ps
module cpev_top (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic                     fetch_req,
  output logic [31:0]              fetch_addr,
  input  wire logic                fetch_ack,
  input  wire cpev_pkg::cpev_fin_t fetch_in,
  input  wire logic [1:0]          data_hits,
  input  wire logic                data_viol,
  input  wire logic                irq_req,
  input  wire logic [13:0]         irq_offset,
  output logic                     irq_ack,
  input  wire logic                dbg_req,
  output logic                     debug_active,
  output logic                     stk_push,
  output cpev_pkg::cpev_ctx_t      stk_wdata,
  output logic                     stk_pop,
  input  wire logic                stk_rvalid,
  input  wire cpev_pkg::cpev_ctx_t stk_rdata,
  output logic                     retire_valid,
  output logic [31:0]              retire_pc,
  output logic                     flush
);
  typedef enum logic [0:0] {ST_RUN, ST_POP} cpev_st_t;

  cpev_st_t            st_q;
  cpev_pkg::cpev_tok_t fe_q;
  cpev_pkg::cpev_tok_t de_q;
  cpev_pkg::cpev_tok_t ex_q;
  cpev_pkg::cpev_sr_t  sr_q;
  cpev_pkg::cpev_sr_t  sr_d;
  logic [31:0]         fa_q;
  logic [31:0]         event_vector_base_q;
  logic [31:0]         dra_q;
  logic [31:0]         drs_q;
  logic [31:0]         cause_q;
  logic [3:0]          cnt_q;
  logic [3:0]          cnt_ld;
  logic                ap_wr_q;
  logic                ap_rd_q;
  logic                rd_wait_q;
  logic [7:0]          ap_ad_q;
  logic [31:0]         hrdata_q;
  logic                irq_ack_q;
  logic                push_q;
  logic                pop_q;
  cpev_pkg::cpev_ctx_t push_d_q;
  logic                ret_q;
  logic [31:0]         ret_pc_q;
  logic                flush_q;
  logic [cpev_pkg::NEV-1:0] pend;
  logic                ev_any;
  logic [2:0]          ev_sel;
  logic                done;
  logic                take;
  logic                is_ret;
  logic                redirect;
  logic                ex_free;
  logic                adv_de;
  logic                adv_fe;
  logic                is_mem;
  logic                sr_wr;
  logic [31:0]         hnd;
  logic [31:0]         rd_mux;

  // Execute completes once the hold count has run out
  assign done     = ex_q.valid && cnt_q == 4'h0 && st_q == ST_RUN; // RULE4
  assign is_mem   = ex_q.unit == cpev_pkg::U_MEM; // RULE2
  assign is_ret   = ex_q.kind == cpev_pkg::K_RETS || ex_q.kind == cpev_pkg::K_RETD;

  // Events are only taken from the execute stage, the oldest instruction
  always_comb begin
    pend = '0;
    pend[cpev_pkg::EV_DBG]   = dbg_req && !sr_q.dbg_mask && !sr_q.dbg_active; // RULE8
    pend[cpev_pkg::EV_MULTI] = ex_q.imulti || (is_mem && data_hits >= 2'h2); // RULE18
    pend[cpev_pkg::EV_IMISS] = ex_q.imiss; // RULE17
    pend[cpev_pkg::EV_IPROT] = ex_q.iprot; // RULE16
    pend[cpev_pkg::EV_DMISS] = is_mem && data_hits == 2'h0; // RULE17
    pend[cpev_pkg::EV_DPROT] = is_mem && data_hits == 2'h1 && data_viol; // RULE16
    pend[cpev_pkg::EV_SCALL] = ex_q.kind == cpev_pkg::K_SCALL;
    pend[cpev_pkg::EV_IRQ]   = irq_req && !sr_q.dbg_active;
    if (!done) begin
      pend = '0; // RULE22
    end
  end

  cpev_prio_pick #(
    .N     (cpev_pkg::NEV),
    .W     (3),
    .ORDER (cpev_pkg::PRIO_ORDER)
  ) u_pick (
    .req         (pend),
    .grant_valid (ev_any),
    .grant_idx   (ev_sel)
  );

  assign take     = ev_any; // RULE21
  assign redirect = take || (done && is_ret);
  assign ex_free  = st_q == ST_RUN && (!ex_q.valid || (done && !redirect));
  assign adv_de   = de_q.valid && ex_free; // RULE5
  assign adv_fe   = fe_q.valid && (!de_q.valid || adv_de);
  assign fetch_req = st_q == ST_RUN && !redirect && (!fe_q.valid || adv_fe);

  // Handler address for the chosen event
  always_comb begin
    unique case (ev_sel)
      cpev_pkg::EV_DBG:   hnd = event_vector_base_q + cpev_pkg::OFS_DBG; // RULE9
      cpev_pkg::EV_MULTI: hnd = event_vector_base_q + cpev_pkg::OFS_MULTI; // RULE15
      cpev_pkg::EV_IMISS: hnd = event_vector_base_q + cpev_pkg::OFS_IMISS; // RULE14
      cpev_pkg::EV_IPROT: hnd = event_vector_base_q + cpev_pkg::OFS_IPROT; // RULE15
      cpev_pkg::EV_DMISS: hnd = event_vector_base_q + cpev_pkg::OFS_DMISS; // RULE14
      cpev_pkg::EV_DPROT: hnd = event_vector_base_q + cpev_pkg::OFS_DPROT; // RULE15
      cpev_pkg::EV_SCALL: hnd = event_vector_base_q + cpev_pkg::OFS_SCALL; // RULE14
      cpev_pkg::EV_IRQ:   hnd = event_vector_base_q + {18'h0, irq_offset}; // RULE19 RULE20
    endcase
  end

  // Stage registers
  always_ff @(posedge clk) begin
    if (sys_rst || redirect) begin
      fe_q <= '0;
      de_q <= '0;
    end else begin
      if (fetch_req && fetch_ack) begin // RULE1
        fe_q.valid  <= 1'b1;
        fe_q.pc     <= fa_q;
        fe_q.kind   <= fetch_in.kind;
        fe_q.unit   <= fetch_in.unit;
        fe_q.cycles <= fetch_in.cycles;
        fe_q.imiss  <= fetch_in.hits == 2'h0;
        fe_q.imulti <= fetch_in.hits >= 2'h2;
        fe_q.iprot  <= fetch_in.hits == 2'h1 && fetch_in.viol;
      end else if (adv_fe) begin
        fe_q.valid <= 1'b0;
      end
      if (adv_fe) begin
        de_q <= fe_q; // RULE1 RULE3
      end else if (adv_de) begin
        de_q.valid <= 1'b0;
      end
    end
  end

  always_comb begin
    cnt_ld = de_q.cycles;
    if (de_q.unit == cpev_pkg::U_PROD && de_q.cycles < cpev_pkg::PROD_MIN_CYC) begin
      cnt_ld = cpev_pkg::PROD_MIN_CYC; // RULE2
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ex_q  <= '0;
      cnt_q <= 4'h0;
    end else if (redirect) begin
      ex_q  <= '0;
      cnt_q <= 4'h0;
    end else if (ex_free) begin
      ex_q  <= adv_de ? de_q : '0; // RULE1 RULE3
      cnt_q <= adv_de ? cnt_ld : 4'h0;
    end else if (ex_q.valid && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1; // RULE4
    end
  end

  // Fetch address and return sequencing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fa_q <= cpev_pkg::RESET_ADDR; // RULE13
      st_q <= ST_RUN;
    end else begin
      unique case (st_q)
        ST_RUN: begin
          if (take) begin
            fa_q <= hnd;
          end else if (done && ex_q.kind == cpev_pkg::K_RETD) begin
            fa_q <= dra_q; // RULE12
          end else if (done && ex_q.kind == cpev_pkg::K_RETS) begin
            st_q <= ST_POP;
          end else if (fetch_req && fetch_ack) begin
            fa_q <= fa_q + 32'h4;
          end
        end
        ST_POP: begin
          if (stk_rvalid) begin
            fa_q <= stk_rdata.ra; // RULE7
            st_q <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Status word
  assign sr_wr = ap_wr_q && ap_ad_q == cpev_pkg::A_SR;
  always_comb begin
    sr_d = sr_q;
    if (sr_wr) begin
      sr_d = (sr_q & ~cpev_pkg::SR_WMASK) | (hwdata & cpev_pkg::SR_WMASK); // RULE6
      if (!sr_q.dbg_active && sr_q.mode == cpev_pkg::MODE_APP) begin
        sr_d.mode = sr_q.mode;
      end
      sr_d.dbg_active = sr_q.dbg_active; // RULE11
    end
    if (take) begin
      sr_d.mode = cpev_pkg::MODE_EXC;
      if (ev_sel == cpev_pkg::EV_DBG) begin
        sr_d.dbg_active = 1'b1; // RULE9 RULE10
      end else if (ev_sel == cpev_pkg::EV_SCALL) begin
        sr_d.mode = cpev_pkg::MODE_SUP;
      end else if (ev_sel == cpev_pkg::EV_IRQ) begin
        sr_d.mode = cpev_pkg::MODE_INT;
      end
    end else if (done && ex_q.kind == cpev_pkg::K_RETD) begin
      sr_d = drs_q; // RULE12
      sr_d.dbg_active = 1'b0;
    end else if (st_q == ST_POP && stk_rvalid) begin
      sr_d = stk_rdata.sr; // RULE7
    end
    sr_d.rsv_hi = 4'h0;
    sr_d.rsv_lo = 8'h00;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sr_q <= cpev_pkg::SR_RESET;
    end else begin
      sr_q <= sr_d;
    end
  end

  // Context save, debug return registers, cause
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dra_q   <= '0;
      drs_q   <= '0;
      cause_q <= '0;
      push_q  <= 1'b0;
      push_d_q <= '0;
    end else begin
      push_q <= 1'b0;
      if (take && ev_sel == cpev_pkg::EV_DBG) begin
        dra_q <= ex_q.pc; // RULE10
        drs_q <= sr_q;
      end else if (ap_wr_q && ap_ad_q == cpev_pkg::A_DRA) begin
        dra_q <= hwdata;
      end else if (ap_wr_q && ap_ad_q == cpev_pkg::A_DRS) begin
        drs_q <= hwdata;
      end
      if (take && ev_sel != cpev_pkg::EV_DBG) begin
        push_q      <= 1'b1; // RULE7
        push_d_q.sr <= sr_q;
        push_d_q.ra <= ev_sel == cpev_pkg::EV_SCALL ? ex_q.pc + 32'h4 : ex_q.pc;
      end
      if (take) begin
        cause_q <= {29'h0, ev_sel};
      end
    end
  end

  // Pulses toward the partners
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_ack_q <= 1'b0;
      pop_q     <= 1'b0;
      ret_q     <= 1'b0;
      ret_pc_q  <= '0;
      flush_q   <= 1'b0;
    end else begin
      irq_ack_q <= take && ev_sel == cpev_pkg::EV_IRQ; // RULE19
      pop_q     <= done && !take && ex_q.kind == cpev_pkg::K_RETS; // RULE7
      ret_q     <= done && !take; // RULE3
      ret_pc_q  <= ex_q.pc;
      flush_q   <= redirect;
    end
  end

  // AHB-Lite slave: zero-wait writes, one wait state on reads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ap_wr_q   <= 1'b0;
      ap_rd_q   <= 1'b0;
      ap_ad_q   <= 8'h00;
      rd_wait_q <= 1'b0;
      hrdata_q  <= '0;
      event_vector_base_q    <= '0;
    end else begin
      if (hready) begin
        ap_wr_q <= hsel && htrans[1] && hwrite;
        ap_rd_q <= hsel && htrans[1] && !hwrite;
        ap_ad_q <= haddr[7:0];
      end
      rd_wait_q <= ap_rd_q && !rd_wait_q;
      if (ap_rd_q && !rd_wait_q) begin
        hrdata_q <= rd_mux;
      end
      if (ap_wr_q && ap_ad_q == cpev_pkg::A_EVENT_VECTOR_BASE) begin
        event_vector_base_q <= {hwdata[31:2], 2'b00};
      end
    end
  end

  always_comb begin
    unique case (ap_ad_q)
      cpev_pkg::A_SR:    rd_mux = sr_q;
      cpev_pkg::A_EVENT_VECTOR_BASE:  rd_mux = event_vector_base_q;
      cpev_pkg::A_DRA:   rd_mux = dra_q;
      cpev_pkg::A_DRS:   rd_mux = drs_q;
      cpev_pkg::A_CAUSE: rd_mux = cause_q;
      cpev_pkg::A_PC:    rd_mux = fa_q;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  assign hreadyout    = !(ap_rd_q && !rd_wait_q);
  assign hresp        = 1'b0;
  assign hrdata       = hrdata_q;
  assign fetch_addr   = fa_q;
  assign irq_ack      = irq_ack_q;
  assign debug_active = sr_q.dbg_active;
  assign stk_push     = push_q;
  assign stk_wdata    = push_d_q;
  assign stk_pop      = pop_q;
  assign retire_valid = ret_q;
  assign retire_pc    = ret_pc_q;
  assign flush        = flush_q;

  // Checks
  sequence s_pop;
    (st_q == ST_POP) ##0 stk_rvalid;
  endsequence

  property p_reset_addr;
    @(posedge clk) $fell(sys_rst) |-> fa_q == cpev_pkg::RESET_ADDR;
  endproperty
  a_reset_addr: assert property (p_reset_addr) else $error("bad reset fetch"); // RULE13

  property p_dbg_mask;
    @(posedge clk) disable iff (sys_rst)
      sr_q.dbg_mask && !sr_q.dbg_active |=> !$rose(sr_q.dbg_active);
  endproperty
  a_dbg_mask: assert property (p_dbg_mask) else $error("masked debug taken"); // RULE8

  property p_dbg_entry;
    @(posedge clk) disable iff (sys_rst)
      take && ev_sel == cpev_pkg::EV_DBG
      |=> sr_q.dbg_active && fa_q == $past(event_vector_base_q) + cpev_pkg::OFS_DBG;
  endproperty
  a_dbg_entry: assert property (p_dbg_entry) else $error("bad debug entry"); // RULE9

  property p_dbg_save;
    @(posedge clk) disable iff (sys_rst)
      take && ev_sel == cpev_pkg::EV_DBG |=> dra_q == $past(ex_q.pc) && !stk_push;
  endproperty
  a_dbg_save: assert property (p_dbg_save) else $error("bad debug save"); // RULE10

  property p_dbg_ret;
    @(posedge clk) disable iff (sys_rst)
      done && !take && ex_q.kind == cpev_pkg::K_RETD
      |=> fa_q == $past(dra_q) && !sr_q.dbg_active;
  endproperty
  a_dbg_ret: assert property (p_dbg_ret) else $error("bad debug return"); // RULE12

  property p_scall_push;
    @(posedge clk) disable iff (sys_rst)
      take && ev_sel == cpev_pkg::EV_SCALL
      |=> stk_push && stk_wdata.ra == $past(ex_q.pc) + 32'h4
          && fa_q == $past(event_vector_base_q) + cpev_pkg::OFS_SCALL;
  endproperty
  a_scall_push: assert property (p_scall_push) else $error("bad call push"); // RULE7

  property p_rets_pop;
    @(posedge clk) disable iff (sys_rst)
      s_pop |=> fa_q == $past(stk_rdata.ra) && st_q == ST_RUN;
  endproperty
  a_rets_pop: assert property (p_rets_pop) else $error("bad return pop"); // RULE7

  property p_irq_vec;
    @(posedge clk) disable iff (sys_rst)
      take && ev_sel == cpev_pkg::EV_IRQ
      |=> irq_ack && fa_q == $past(event_vector_base_q) + {18'h0, $past(irq_offset)};
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("bad irq vector"); // RULE19

  property p_hold;
    @(posedge clk) disable iff (sys_rst)
      ex_q.valid && cnt_q != 4'h0 && st_q == ST_RUN && !redirect
      |=> ex_q.pc == $past(ex_q.pc) && !retire_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("multi-cycle not held"); // RULE4

  property p_oldest;
    @(posedge clk) disable iff (sys_rst)
      ev_any |-> done;
  endproperty
  a_oldest: assert property (p_oldest) else $error("younger event taken"); // RULE22
endmodule

// File: verification/cpev_partner.sv
`timescale 1ns/1ps
module cpev_partner (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                fetch_req,
  input  wire logic [31:0]         fetch_addr,
  output cpev_pkg::cpev_fin_t      fetch_in,
  output logic                     fetch_ack,
  output logic [1:0]               data_hits,
  output logic                     data_viol,
  output logic                     irq_req,
  output logic [13:0]              irq_offset,
  input  wire logic                irq_ack,
  output logic                     dbg_req,
  input  wire logic                debug_active,
  input  wire logic                stk_push,
  input  wire cpev_pkg::cpev_ctx_t stk_wdata,
  input  wire logic                stk_pop,
  output logic                     stk_rvalid,
  output cpev_pkg::cpev_ctx_t      stk_rdata
);
  // Plain one-cycle arithmetic instruction with a single clean hit
  localparam cpev_pkg::cpev_fin_t NOP = 11'h002;
  cpev_pkg::cpev_fin_t q[$];
  cpev_pkg::cpev_ctx_t stk[$];
  logic [31:0]         tag_pc = 32'h0;
  logic                irq_go = 1'b0;
  logic                dbg_go = 1'b0;
  logic [13:0]         irq_ofs = 14'h0;
  logic [1:0]          dh = 2'h1;
  logic                dv = 1'b0;
  int                  pend = 0;
  initial begin
    fetch_in = NOP;
    fetch_ack = 1'b0;
    stk_rvalid = 1'b0;
    stk_rdata = '0;
  end
  // Instruction memory with random stalls
  always @(posedge clk) begin
    fetch_ack <= ($urandom_range(3) != 0);
    if (sys_rst) begin
      fetch_in <= NOP;
    end else if (fetch_req && fetch_ack) begin
      if (fetch_in !== NOP) tag_pc <= fetch_addr;
      fetch_in <= (q.size() > 0) ? q.pop_front() : NOP;
    end
  end
  // System stack, slow pop answer, stale data inverted
  always @(posedge clk) begin
    if (stk_push) stk.push_back(stk_wdata);
    stk_rvalid <= 1'b0;
    stk_rdata <= ~stk_rdata;
    if (stk_pop) pend <= 1 + $urandom_range(3);
    else if (pend > 0) pend <= pend - 1;
    if (pend == 1 && stk.size() > 0) begin
      stk_rvalid <= 1'b1;
      stk_rdata <= stk.pop_back();
    end
  end
  // Interrupt and debug requests held until taken
  always @(posedge clk) begin
    if (irq_ack) irq_go = 1'b0;
    if (debug_active) dbg_go = 1'b0;
    irq_req <= irq_go;
    irq_offset <= irq_go ? irq_ofs : ~irq_offset;
    dbg_req <= dbg_go;
    data_hits <= dh;
    data_viol <= dv;
  end
endmodule

// File: verification/test_cpev_top.sv
`timescale 1ns/1ps
module test_cpev_top;
  logic                clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic [31:0]         haddr = 32'h0;
  logic [1:0]          htrans = 2'h0;
  logic                hwrite = 1'b0;
  logic [31:0]         hwdata = 32'h0;
  logic                hready;
  logic [31:0]         hrdata, fetch_addr, retire_pc, rd, event_vector_base, dra;
  logic                hreadyout, hresp, fetch_req, fetch_ack, data_viol, irq_req, irq_ack;
  logic                dbg_req, debug_active, stk_push, stk_pop, stk_rvalid, retire_valid, flush;
  logic [1:0]          data_hits;
  logic [13:0]         irq_offset;
  cpev_pkg::cpev_fin_t fetch_in;
  cpev_pkg::cpev_ctx_t stk_wdata, stk_rdata;
  int                  miscompares = 0;
  int                  total_checks = 0;
  int                  n;
  assign hready = hreadyout;
  always #12.5 clk = ~clk;
  cpev_top i_cpev_top (.clk(clk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_in(fetch_in),
    .data_hits(data_hits), .data_viol(data_viol), .irq_req(irq_req),
    .irq_offset(irq_offset), .irq_ack(irq_ack), .dbg_req(dbg_req),
    .debug_active(debug_active), .stk_push(stk_push), .stk_wdata(stk_wdata),
    .stk_pop(stk_pop), .stk_rvalid(stk_rvalid), .stk_rdata(stk_rdata),
    .retire_valid(retire_valid), .retire_pc(retire_pc), .flush(flush));
  cpev_partner i_cpev_partner (.clk(clk), .sys_rst(sys_rst), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_in(fetch_in), .fetch_ack(fetch_ack),
    .data_hits(data_hits), .data_viol(data_viol), .irq_req(irq_req),
    .irq_offset(irq_offset), .irq_ack(irq_ack), .dbg_req(dbg_req),
    .debug_active(debug_active), .stk_push(stk_push), .stk_wdata(stk_wdata),
    .stk_pop(stk_pop), .stk_rvalid(stk_rvalid), .stk_rdata(stk_rdata));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_up(input int k);
    if (k >= 300) begin
      miscompares++;
      wrap_up();
    end
  endtask
  // Single word transfer; address held until hready seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    k = 0;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 300);
    give_up(k);
    htrans <= 2'h0;
    hwdata <= d;
    k = 0;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 300);
    give_up(k);
    rd = hrdata;
  endtask
  task automatic redir(input logic [31:0] e);
    int k;
    k = 0;
    while (flush !== 1'b1 && k < 300) begin @(negedge clk); k++; end
    give_up(k);
    chk("fetch_addr", fetch_addr, e);
    @(negedge clk);
  endtask
  // One faulting instruction: handler, stacked return address, cause
  task automatic exc(input cpev_pkg::cpev_fin_t f, input logic [1:0] h, input logic v,
                     input logic [31:0] o, input logic [2:0] e);
    i_cpev_partner.dh = h;
    i_cpev_partner.dv = v;
    i_cpev_partner.q.push_back(f);
    redir(event_vector_base + o);
    chk("stack ra", i_cpev_partner.stk[$].ra,
        i_cpev_partner.tag_pc + ((f.kind == cpev_pkg::K_SCALL) ? 32'h4 : 32'h0));
    i_cpev_partner.dh = 2'h1;
    i_cpev_partner.dv = 1'b0;
    bus(1'b0, cpev_pkg::A_CAUSE, 32'h0);
    chk("cause", rd, {29'h0, e});
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h8ec10429));
    event_vector_base = $urandom() & 32'h7fff_ff00;
    i_cpev_partner.q.push_back(11'h08a);
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("reset fetch", fetch_addr, cpev_pkg::RESET_ADDR);
    for (int i = 0; i < 3; i++) begin
      n = 0;
      do begin @(negedge clk); n++; end while (retire_valid !== 1'b1 && n < 300);
      give_up(n);
      chk("retire_pc", retire_pc, cpev_pkg::RESET_ADDR + 32'(4 * i));
      if (i == 1) chk("product hold", 32'(n > cpev_pkg::PROD_MIN_CYC), 32'h1);
    end
    bus(1'b0, cpev_pkg::A_SR, 32'h0);
    chk("status", rd, cpev_pkg::SR_RESET);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, cpev_pkg::A_EVENT_VECTOR_BASE, event_vector_base);
    bus(1'b0, cpev_pkg::A_EVENT_VECTOR_BASE, 32'h0);
    chk("event_vector_base", rd, event_vector_base);
    exc(11'h000, 2'h1, 1'b0, cpev_pkg::OFS_IMISS, cpev_pkg::EV_IMISS);
    exc(11'h004, 2'h1, 1'b0, cpev_pkg::OFS_MULTI, cpev_pkg::EV_MULTI);
    exc(11'h003, 2'h1, 1'b0, cpev_pkg::OFS_IPROT, cpev_pkg::EV_IPROT);
    exc(11'h102, 2'h0, 1'b0, cpev_pkg::OFS_DMISS, cpev_pkg::EV_DMISS);
    exc(11'h102, 2'h1, 1'b1, cpev_pkg::OFS_DPROT, cpev_pkg::EV_DPROT);
    exc(11'h202, 2'h1, 1'b0, cpev_pkg::OFS_SCALL, cpev_pkg::EV_SCALL);
    i_cpev_partner.q.push_back(11'h402);
    n = 0;
    while (stk_rvalid !== 1'b1 && n < 300) begin @(negedge clk); n++; end
    give_up(n);
    dra = stk_rdata.ra;
    @(negedge clk);
    chk("return", fetch_addr, dra);
    for (int i = 0; i < 2; i++) begin
      i_cpev_partner.irq_ofs = (i == 0) ? 14'(($urandom() & 32'h3ffc) | 32'h200) : 14'h3ffc;
      i_cpev_partner.irq_go = 1'b1;
      redir(event_vector_base + {18'h0, i_cpev_partner.irq_ofs});
    end
    bus(1'b1, cpev_pkg::A_SR, 32'h0480_0000);
    i_cpev_partner.dbg_go = 1'b1;
    repeat (40) @(negedge clk);
    chk("masked debug", {31'h0, debug_active}, 32'h0);
    bus(1'b1, cpev_pkg::A_SR, 32'h0080_0000);
    redir(event_vector_base + cpev_pkg::OFS_DBG);
    chk("debug active", {31'h0, debug_active}, 32'h1);
    bus(1'b1, cpev_pkg::A_SR, 32'h0000_0000);
    bus(1'b0, cpev_pkg::A_SR, 32'h0);
    chk("debug mode", {29'h0, rd[25:23]}, {29'h0, cpev_pkg::MODE_APP});
    chk("debug flag", {31'h0, rd[27]}, 32'h1);
    bus(1'b0, cpev_pkg::A_DRA, 32'h0);
    dra = rd;
    i_cpev_partner.q.push_back(11'h602);
    n = 0;
    while (debug_active !== 1'b0 && n < 300) begin @(negedge clk); n++; end
    give_up(n);
    chk("debug return", fetch_addr, dra);
    bus(1'b0, cpev_pkg::A_SR, 32'h0);
    chk("restored mode", {29'h0, rd[25:23]}, {29'h0, cpev_pkg::MODE_SUP});
    wrap_up();
  end
endmodule
